// file: rtl/rtc_pkg.sv
package rtc_pkg;
    localparam logic [6:0] RTC_SLAVE_ID   = 7'h68;
    localparam logic [7:0] RTC_PTR_RESET  = 8'h00;
    localparam logic [7:0] RTC_PTR_LAST   = 8'h13;
    localparam int         RTC_NUM_REGS   = 20;
    localparam int         RTC_CLK_MHZ    = 125;
    localparam int         RTC_SCL_NS     = 2480;
    localparam int         RTC_SCL_HALF   = (RTC_SCL_NS * RTC_CLK_MHZ) / 2000;
    localparam int         RTC_PWRUP_CYC  = 16;
    localparam int         RTC_BUF_DEPTH  = 2;
endpackage

// file: rtl/rtc_bus_if.sv
`timescale 1ns/10ps
interface rtc_bus_if;
    logic scl_o;
    logic sda_m_oe_n;
    logic sda_s_oe_n;
    wire  sda = ~(~sda_m_oe_n | ~sda_s_oe_n);
    modport device (input scl_o, input sda, output sda_s_oe_n);
    modport master (output scl_o, input sda, output sda_m_oe_n);
endinterface

// file: rtl/rtc_slave.sv
`timescale 1ns/10ps
// Behaviour
// - device is slave only, master clocks
// - bytes shift msb first
// - sda changes only while scl low
// - sda released after power-up
// - detect start, ignore bus until then
// - start during power-up ignored
// - stop returns device to idle
// - receiver acks in ninth clock
// - ack address, word address, write data
// - master acks read bytes for more
// - compare upper seven bits with 1101000
// - lsb selects read or write
// - byte after address is word address
// - pointer resets to zero
// - master repeats same slave id
// - write: start, id, address, data, stop
// - read: id, address, restart, id read
// - send bytes while master acks
// - pointer loads and increments per byte
// - pointer wraps after 13h to 00h
module rtc_slave
    import rtc_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    rtc_bus_if.device       bus,
    input  wire logic [7:0] rd_data_i,
    output logic      [4:0] rd_addr_o,
    output logic            wr_en_o,
    output logic      [4:0] wr_addr_o,
    output logic      [7:0] wr_data_o,
    output logic            busy_o
);
    typedef enum logic [2:0] {RTC_IDLE, RTC_ID, RTC_WADDR, RTC_WDATA, RTC_RDATA,
                              RTC_IGNORE} rtc_state_e;
    rtc_state_e state;
    logic [1:0] scl_sync, sda_sync;
    logic       scl_q, sda_q;
    logic [4:0] pwr_cnt;
    logic [3:0] bit_cnt;
    logic [7:0] shreg, txreg;
    logic [7:0] ptr;
    logic       ack_phase, is_read, rd_ack_fail;
    wire scl = scl_sync[1];
    wire sda = sda_sync[1];
    wire scl_rise = scl & ~scl_q;
    wire scl_fall = ~scl & scl_q;
    wire powered  = (pwr_cnt == 5'(RTC_PWRUP_CYC));
    wire start_c  = scl & scl_q & sda_q & ~sda & powered;
    wire stop_c   = scl & scl_q & ~sda_q & sda;
    wire [7:0] next_ptr = (ptr == RTC_PTR_LAST) ? 8'h00 : ptr + 8'h01;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], bus.scl_o};
            sda_sync <= {sda_sync[0], bus.sda};
            scl_q    <= scl;
            sda_q    <= sda;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) pwr_cnt <= 5'h00;
        else if (!powered) pwr_cnt <= pwr_cnt + 5'h01;
    end

    // protocol engine; data lines change only after scl falls
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state       <= RTC_IDLE;
            bit_cnt     <= 4'h0;
            shreg       <= 8'h00;
            txreg       <= 8'h00;
            ptr         <= RTC_PTR_RESET;
            ack_phase   <= 1'b0;
            is_read     <= 1'b0;
            rd_ack_fail <= 1'b0;
            bus.sda_s_oe_n <= 1'b1;
            wr_en_o     <= 1'b0;
            wr_addr_o   <= 5'h00;
            wr_data_o   <= 8'h00;
        end else begin
            wr_en_o <= 1'b0;
            if (start_c) begin
                state     <= RTC_ID;
                bit_cnt   <= 4'h0;
                ack_phase <= 1'b0;
                bus.sda_s_oe_n <= 1'b1;
            end else if (stop_c) begin
                state     <= RTC_IDLE;
                bus.sda_s_oe_n <= 1'b1;
            end else if (state != RTC_IDLE && state != RTC_IGNORE) begin
                if (scl_rise && !ack_phase) begin
                    shreg   <= {shreg[6:0], sda};
                    bit_cnt <= bit_cnt + 4'h1;
                end
                if (scl_rise && ack_phase && state == RTC_RDATA)
                    rd_ack_fail <= sda;
                if (scl_fall) begin
                    if (!ack_phase && bit_cnt == 4'h8) begin
                        ack_phase <= 1'b1;
                        bit_cnt   <= 4'h0;
                        case (state)
                            RTC_ID: begin
                                if (shreg[7:1] == RTC_SLAVE_ID) begin
                                    bus.sda_s_oe_n <= 1'b0;
                                    is_read <= shreg[0];
                                end else begin
                                    state <= RTC_IGNORE;
                                end
                            end
                            RTC_WADDR: begin
                                ptr <= shreg;
                                bus.sda_s_oe_n <= 1'b0;
                            end
                            RTC_WDATA: begin
                                wr_en_o   <= 1'b1;
                                wr_addr_o <= ptr[4:0];
                                wr_data_o <= shreg;
                                ptr       <= next_ptr;
                                bus.sda_s_oe_n <= 1'b0;
                            end
                            RTC_RDATA: begin
                                bus.sda_s_oe_n <= 1'b1;
                                ptr <= next_ptr;
                            end
                            default: state <= RTC_IGNORE;
                        endcase
                    end else if (ack_phase) begin
                        ack_phase <= 1'b0;
                        case (state)
                            RTC_ID: begin
                                if (is_read) begin
                                    state <= RTC_RDATA;
                                    txreg <= {rd_data_i[6:0], 1'b0};
                                    bus.sda_s_oe_n <= rd_data_i[7];
                                    bit_cnt <= 4'h0;
                                end else begin
                                    state <= RTC_WADDR;
                                    bus.sda_s_oe_n <= 1'b1;
                                end
                            end
                            RTC_WADDR, RTC_WDATA: begin
                                state <= RTC_WDATA;
                                bus.sda_s_oe_n <= 1'b1;
                            end
                            RTC_RDATA: begin
                                if (rd_ack_fail) begin
                                    state <= RTC_IGNORE;
                                    bus.sda_s_oe_n <= 1'b1;
                                end else begin
                                    txreg <= {rd_data_i[6:0], 1'b0};
                                    bus.sda_s_oe_n <= rd_data_i[7];
                                    bit_cnt <= 4'h0;
                                end
                            end
                            default: state <= RTC_IGNORE;
                        endcase
                    end else if (state == RTC_RDATA) begin
                        bus.sda_s_oe_n <= txreg[7];
                        txreg <= {txreg[6:0], 1'b0};
                    end
                end
            end
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_addr_o <= 5'h00;
            busy_o    <= 1'b0;
        end else begin
            rd_addr_o <= ptr[4:0];
            busy_o    <= (state != RTC_IDLE);
        end
    end
    // read bit count: first bit goes out with ack release, remaining seven on falls
    // shreg also advances on read bits harmlessly; bit_cnt drives ack timing
endmodule // rtc_slave

// file: rtl/rtc_master.sv
`timescale 1ns/10ps
module rtc_master
    import rtc_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    rtc_bus_if.master       bus,
    input  wire logic       req_valid_i,
    output logic            req_ready_o,
    input  wire logic       req_read_i,
    input  wire logic [7:0] req_addr_i,
    input  wire logic [7:0] req_data_i,
    input  wire logic [7:0] req_count_i,
    output logic            rsp_valid_o,
    input  wire logic       rsp_ready_i,
    output logic      [7:0] rsp_data_o,
    output logic            nack_o
);
    typedef enum logic [3:0] {RTM_IDLE, RTM_START, RTM_BYTE, RTM_ACK, RTM_RSTART,
                              RTM_RBYTE, RTM_RACK, RTM_STOP, RTM_WAIT} rtm_state_e;
    rtm_state_e state;
    logic [1:0]  sda_sync;
    logic [8:0]  div;
    logic [1:0]  phase;
    logic [2:0]  bidx, step;
    logic [7:0]  tx, rx, left;
    logic        rd;
    logic [7:0]  addr_l, data_l;
    logic [7:0]  buf_d [RTC_BUF_DEPTH];
    logic [1:0]  buf_n;
    logic        buf_wp, buf_rp;
    wire tick = (div == 9'(RTC_SCL_HALF - 1));
    wire sda  = sda_sync[1];
    wire buf_full = (buf_n == 2'(RTC_BUF_DEPTH));
    wire push = tick && state == RTM_RACK && phase == 2'h0;
    wire pop  = rsp_valid_o && rsp_ready_i;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sda_sync <= 2'h3;
            div      <= 9'h000;
        end else begin
            sda_sync <= {sda_sync[0], bus.sda};
            div      <= tick ? 9'h000 : div + 9'h001;
        end
    end

    // each written bit spends three ticks: scl low (phase0), sda set (phase1), then high (phase2)
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= RTM_IDLE;
            bus.scl_o <= 1'b1;
            bus.sda_m_oe_n <= 1'b1;
            phase <= 2'h0;
            bidx <= 3'h0;
            step <= 3'h0;
            tx <= 8'h00;
            rx <= 8'h00;
            left <= 8'h00;
            rd <= 1'b0;
            addr_l <= 8'h00;
            data_l <= 8'h00;
            nack_o <= 1'b0;
            req_ready_o <= 1'b0;
        end else begin
            req_ready_o <= 1'b0;
            if (state == RTM_IDLE && req_valid_i && !req_ready_o) begin
                req_ready_o <= 1'b1;
                rd <= req_read_i;
                addr_l <= req_addr_i;
                data_l <= req_data_i;
                left <= req_count_i;
                step <= 3'h0;
                nack_o <= 1'b0;
                state <= RTM_START;
                phase <= 2'h0;
            end else if (tick) begin
                phase <= phase + 2'h1;
                case (state)
                    RTM_START, RTM_RSTART: begin
                        if (phase == 2'h0) begin
                            // restart: drop scl first so the slave lets go of its ack
                            if (state == RTM_RSTART) bus.scl_o <= 1'b0;
                            bus.sda_m_oe_n <= 1'b1;
                        end else if (phase == 2'h1) begin
                            bus.scl_o <= 1'b1;
                        end else begin
                            bus.sda_m_oe_n <= 1'b0;
                            phase <= 2'h0;
                            bidx <= 3'h7;
                            tx <= (state == RTM_RSTART) ? {RTC_SLAVE_ID, 1'b1}
                                                        : {RTC_SLAVE_ID, 1'b0};
                            state <= RTM_BYTE;
                        end
                    end
                    RTM_BYTE: begin
                        if (phase == 2'h0) begin
                            bus.scl_o <= 1'b0;
                        end else if (phase == 2'h1) begin
                            bus.sda_m_oe_n <= tx[bidx];
                        end else begin
                            bus.scl_o <= 1'b1;
                            phase <= 2'h0;
                            if (bidx == 3'h0) state <= RTM_ACK;
                            bidx <= bidx - 3'h1;
                        end
                    end
                    RTM_ACK: begin
                        if (phase == 2'h0) begin
                            bus.scl_o <= 1'b0;
                        end else if (phase == 2'h1) begin
                            bus.sda_m_oe_n <= 1'b1;
                        end else if (phase == 2'h2) begin
                            bus.scl_o <= 1'b1;
                        end else begin
                            phase <= 2'h0;
                            step <= step + 3'h1;
                            bidx <= 3'h7;
                            if (sda) begin
                                nack_o <= 1'b1;
                                state <= RTM_STOP;
                            end else if (step == 3'h0) begin
                                tx <= addr_l;
                                state <= RTM_BYTE;
                            end else if (step == 3'h1 && rd) begin
                                state <= RTM_RSTART;
                            end else if (step == 3'h1) begin
                                tx <= data_l;
                                state <= RTM_BYTE;
                            end else if (step == 3'h2 && rd) begin
                                state <= RTM_RBYTE;
                            end else begin
                                state <= RTM_STOP;
                            end
                        end
                    end
                    RTM_RBYTE: begin
                        if (phase == 2'h0) begin
                            bus.scl_o <= 1'b0;
                            bus.sda_m_oe_n <= 1'b1;
                        end else if (phase == 2'h1) begin
                            bus.scl_o <= 1'b1;
                        end else begin
                            rx <= {rx[6:0], sda};
                            phase <= 2'h0;
                            if (bidx == 3'h0) state <= RTM_RACK;
                            bidx <= bidx - 3'h1;
                        end
                    end
                    RTM_RACK: begin
                        if (phase == 2'h0) begin
                            if (buf_full) phase <= 2'h0;
                            else begin
                                bus.scl_o <= 1'b0;
                                left <= left - 8'h01;
                            end
                        end else if (phase == 2'h1) begin
                            bus.sda_m_oe_n <= (left == 8'h00);
                        end else if (phase == 2'h2) begin
                            bus.scl_o <= 1'b1;
                        end else begin
                            phase <= 2'h0;
                            bidx <= 3'h7;
                            state <= (left == 8'h00) ? RTM_STOP : RTM_RBYTE;
                        end
                    end
                    RTM_STOP: begin
                        if (phase == 2'h0) begin
                            bus.scl_o <= 1'b0;
                        end else if (phase == 2'h1) begin
                            bus.sda_m_oe_n <= 1'b0;
                        end else if (phase == 2'h2) begin
                            bus.scl_o <= 1'b1;
                        end else begin
                            bus.sda_m_oe_n <= 1'b1;
                            state <= RTM_IDLE;
                        end
                    end
                    default: begin
                        phase <= 2'h0;
                    end
                endcase
            end
        end
    end

    // two-entry buffer; a full buffer holds scl high so no read byte is lost
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            buf_n <= 2'h0;
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_data_o <= 8'h00;
            buf_d[0] <= 8'h00;
            buf_d[1] <= 8'h00;
        end else begin
            if (push && !buf_full) begin
                buf_d[buf_wp] <= rx;
                buf_wp <= ~buf_wp;
            end
            if (pop) buf_rp <= ~buf_rp;
            buf_n <= buf_n + 2'((push && !buf_full) ? 1 : 0) - 2'(pop ? 1 : 0);
            if (!rsp_valid_o || pop) begin
                if (pop ? (buf_n > 2'h1) : (buf_n != 2'h0)) begin
                    rsp_valid_o <= 1'b1;
                    rsp_data_o <= buf_d[pop ? ~buf_rp : buf_rp];
                end else begin
                    rsp_valid_o <= 1'b0;
                end
            end
        end
    end
endmodule // rtc_master

// file: test/rtc_bus_sva.sv
`timescale 1ns/10ps
module rtc_bus_sva
    import rtc_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic resetn_i,
    input  wire logic scl_o,
    input  wire logic sda,
    input  wire logic sda_m_oe_n,
    input  wire logic sda_s_oe_n
);
    localparam int SCL_MIN = 100;
    logic       scl_q;
    logic       sda_q;
    logic       in_xfer;
    logic       dir_rd;
    logic       id_ok;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] nbytes;
    logic [7:0] hi_cnt;
    wire        start_ev = scl_o && scl_q && sda_q && !sda;
    wire        stop_ev  = scl_o && scl_q && !sda_q && sda;
    wire        rise_ev  = scl_o && !scl_q;
    wire        ack_pt   = rise_ev && bitcnt == 4'h8;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_q  <= 1'h1;
            sda_q  <= 1'h1;
            hi_cnt <= 8'h00;
        end else begin
            scl_q  <= scl_o;
            sda_q  <= sda;
            // saturates so an idle bus cannot wrap to a short count
            hi_cnt <= !scl_o ? 8'h00 : (hi_cnt == 8'hFF ? hi_cnt : hi_cnt + 8'h01);
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            in_xfer <= 1'h0;
            dir_rd  <= 1'h0;
            id_ok   <= 1'h0;
            bitcnt  <= 4'h0;
            shreg   <= 8'h00;
            nbytes  <= 8'h00;
        end else if (start_ev) begin
            in_xfer <= 1'h1;
            bitcnt  <= 4'h0;
            nbytes  <= 8'h00;
        end else if (stop_ev) begin
            in_xfer <= 1'h0;
        end else if (ack_pt) begin
            bitcnt <= 4'h0;
            nbytes <= nbytes + 8'h01;
            if (nbytes == 8'h00) begin
                dir_rd <= shreg[0];
                id_ok  <= shreg[7:1] == RTC_SLAVE_ID;
            end
        end else if (rise_ev) begin
            shreg  <= {shreg[6:0], sda};
            bitcnt <= bitcnt + 4'h1;
        end
    end

    a_released_after_reset: assert property (!$past(resetn_i) |-> sda_s_oe_n && scl_o)
        else $error("slave or clock not released after reset");
    a_quiet_until_start: assert property (!in_xfer |-> sda_s_oe_n)
        else $error("slave drives sda outside a transfer");
    a_stable_scl_high: assert property (scl_o && $past(scl_o) |-> $stable(sda_s_oe_n))
        else $error("slave changed sda while scl high");
    a_no_clash_high: assert property (scl_o && !sda_s_oe_n |-> sda_m_oe_n)
        else $error("both ends drive sda while scl high");
    a_id_acked: assert property (ack_pt && nbytes == 8'h00
        && shreg[7:1] == RTC_SLAVE_ID |-> !sda_s_oe_n)
        else $error("matching id not acknowledged");
    a_write_bytes_acked: assert property (ack_pt && nbytes != 8'h00
        && !dir_rd && id_ok |-> !sda_s_oe_n)
        else $error("write byte not acknowledged");
    a_read_ack_free: assert property (ack_pt && nbytes != 8'h00
        && dir_rd && id_ok |-> sda_s_oe_n)
        else $error("slave holds sda in master ack slot");
    a_scl_high_time: assert property ($fell(scl_o) |-> hi_cnt >= SCL_MIN)
        else $error("scl high phase too short");

    c_start: cover property (start_ev);
    c_stop: cover property (stop_ev);
    c_write_data: cover property (ack_pt && !dir_rd && nbytes == 8'h02);
    c_read_data: cover property (ack_pt && dir_rd && nbytes == 8'h03);
endmodule // rtc_bus_sva

// file: test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import rtc_pkg::*;
    localparam int HB = 5; // a third of the 120 ns bench link clock
    logic       clock_i, resetn_i, req_valid, req_read, rsp_ready;
    logic       req_ready, rsp_valid, nack, wr_en, busy, ps, pd;
    logic [7:0] req_addr, req_data, req_count, rsp_data, wr_data, rd_data, wsh;
    logic [4:0] rd_addr, wr_addr;
    logic [3:0] wc;
    logic [7:0] regs [RTC_NUM_REGS];
    int         fails, samples_checked;

    rtc_bus_if bus1 ();
    rtc_bus_if bus2 ();
    assign rd_data = (rd_addr < 5'h14) ? regs[rd_addr] : 8'h00;

    rtc_slave rtc_slave_inst (.clock_i(clock_i), .resetn_i(resetn_i), .bus(bus1),
        .rd_data_i(rd_data), .rd_addr_o(rd_addr), .wr_en_o(wr_en), .wr_addr_o(wr_addr),
        .wr_data_o(wr_data), .busy_o(busy));
    rtc_slave rtc_slave_b_inst (.clock_i(clock_i), .resetn_i(resetn_i), .bus(bus2),
        .rd_data_i(8'h00), .rd_addr_o(), .wr_en_o(), .wr_addr_o(), .wr_data_o(), .busy_o());
    rtc_master rtc_master_inst (.clock_i(clock_i), .resetn_i(resetn_i), .bus(bus1),
        .req_valid_i(req_valid), .req_ready_o(req_ready), .req_read_i(req_read),
        .req_addr_i(req_addr), .req_data_i(req_data), .req_count_i(req_count),
        .rsp_valid_o(rsp_valid), .rsp_ready_i(rsp_ready), .rsp_data_o(rsp_data),
        .nack_o(nack));
    rtc_bus_sva rtc_bus_sva_inst (.clock_i(clock_i), .resetn_i(resetn_i),
        .scl_o(bus1.scl_o), .sda(bus1.sda), .sda_m_oe_n(bus1.sda_m_oe_n),
        .sda_s_oe_n(bus1.sda_s_oe_n));

    initial begin
        clock_i = 1'h0;
        forever #4 clock_i = ~clock_i;
    end

    // register file behind the slave, plus capture of the first byte after each start
    always @(posedge clock_i) begin
        if (wr_en === 1'h1) regs[wr_addr] <= wr_data;
        ps <= bus1.scl_o;
        pd <= bus1.sda;
        if (bus1.scl_o && ps && pd && !bus1.sda) wc <= 4'h0;
        else if (bus1.scl_o && !ps && wc < 4'h8) begin
            wsh <= {wsh[6:0], bus1.sda};
            wc  <= wc + 4'h1;
        end
    end

    task summarize;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task chk_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // 0 request taken, 1 response ready, 2 write strobe, 3 slave idle
    task wait_for(input int w);
        int n;
        for (n = 0; n < 40000; n++) begin
            @(negedge clock_i);
            if ((w == 0 && req_ready === 1'h1) || (w == 1 && rsp_valid === 1'h1) ||
                (w == 2 && wr_en === 1'h1) || (w == 3 && busy === 1'h0)) return;
        end
        fails++;
        summarize();
    endtask

    task request(input logic rd, input logic [7:0] a, input logic [7:0] d, input logic [7:0] c);
        @(posedge clock_i);
        req_valid <= 1'h1;
        req_read  <= rd;
        req_addr  <= a;
        req_data  <= d;
        req_count <= c;
        wait_for(0);
        @(posedge clock_i);
        req_valid <= 1'h0;
    endtask

    task t_write(input logic [7:0] a, input logic [7:0] d);
        request(1'h0, a, d, 8'h01);
        wait_for(2);
        chk_byte({3'h0, wr_addr}, a);
        chk_byte(wr_data, d);
        wait_for(3);
        chk_bit(nack, 1'h0);
        chk_byte(wsh, {RTC_SLAVE_ID, 1'h0});
        $display("write test at %h done", a);
    endtask

    // stall holds the receiver off for that many cycles plus one before rsp_ready is raised
    task t_read(input logic [7:0] a, input int c, input int stall, input logic [31:0] exp);
        int k;
        request(1'h1, a, 8'h00, 8'(c));
        repeat (stall) @(posedge clock_i);
        @(posedge clock_i);
        rsp_ready <= 1'h1;
        for (k = 0; k < c; k++) begin
            wait_for(1);
            chk_byte(rsp_data, exp[8*k +: 8]);
            @(posedge clock_i);
        end
        rsp_ready <= 1'h0;
        wait_for(3);
        chk_bit(nack, 1'h0);
        chk_byte(wsh, {RTC_SLAVE_ID, 1'h1});
        $display("read test at %h done", a);
    endtask

    task bang(input logic [7:0] id, input logic ack_exp);
        int         i;
        logic       ack;
        logic [8:0] frame;
        frame = {id, 1'h1};
        repeat (HB) @(posedge clock_i);
        bus2.sda_m_oe_n <= 1'h0;
        repeat (HB) @(posedge clock_i);
        bus2.scl_o <= 1'h0;
        for (i = 8; i >= 0; i--) begin
            repeat (HB) @(posedge clock_i);
            bus2.sda_m_oe_n <= frame[i];
            repeat (HB) @(posedge clock_i);
            bus2.scl_o <= 1'h1;
            repeat (HB) @(posedge clock_i);
            ack = bus2.sda;
            bus2.scl_o <= 1'h0;
        end
        repeat (HB) @(posedge clock_i);
        bus2.sda_m_oe_n <= 1'h0;
        repeat (HB) @(posedge clock_i);
        bus2.scl_o <= 1'h1;
        repeat (HB) @(posedge clock_i);
        bus2.sda_m_oe_n <= 1'h1;
        chk_bit(ack, ack_exp);
    endtask

    task t_ids;
        bang(8'hA0, 1'h1);
        bang(8'hD0, 1'h0);
        $display("id match test done");
    endtask

    initial begin
        resetn_i        = 1'h0;
        req_valid       = 1'h0;
        req_read        = 1'h0;
        req_addr        = 8'h00;
        req_data        = 8'h00;
        req_count       = 8'h01;
        rsp_ready       = 1'h0;
        bus2.scl_o      = 1'h1;
        bus2.sda_m_oe_n = 1'h1;
        fails           = 0;
        samples_checked = 0;
        for (int i = 0; i < RTC_NUM_REGS; i++) regs[i] = 8'(8'h30 + i);
        repeat (10) @(posedge clock_i);
        resetn_i <= 1'h1;
        // keep clear of the slave's power-up window
        repeat (20) @(posedge clock_i);
        t_write(8'h05, 8'h5A);
        t_read(8'h05, 2, 0, 32'h0000365A);
        t_write(8'h13, 8'hC3);
        t_read(8'h12, 4, 8000, 32'h3130C342);
        t_ids();
        summarize();
    end
endmodule // tb_top
